/* src/cpu_register_file_ccr.v */
// Operation
// [RQ1] Eight 32-bit general registers, any width
// [RQ2] Each splits into extended and base halves
// [RQ3] Extended half bits 31-16, base 15-0
// [RQ4] Base half splits into high, low bytes
// [RQ5] Register seven doubles as stack pointer
// [RQ6] 24-bit pointer, fetch ignores bit zero
// [RQ7] Mask bit blocks all but non-maskable
// [RQ8] Mask bit set at exception start
// [RQ9] Bit six user-writable, also mask
// [RQ10] Half carry from bit 3/11/27
// [RQ11] Bit four plain user bit
// [RQ12] Negative takes result sign bit
// [RQ13] Zero set when result is zero
// [RQ14] Overflow set on arithmetic overflow
// [RQ15] Carry holds carry, borrow, shifted-out bit
// [RQ16] Carry serves as bit accumulator
// [RQ17] Flags loadable, storable, and/or/xor-able
// [RQ18] Branch conditions use N, Z, V, C
// [RQ19] Reset loads pointer, sets mask only
// [RQ20] Software sets stack pointer after reset
// [RQ21] Odd word addresses forced even
// [RQ22] Bit operations select bit 0-7
// [RQ23] Decimal adjust sees two BCD digits
// [RQ24] Stack accesses should be word or long
`timescale 1ns/1ps
`include "cpu_register_file_ccr_regs.vh"
module cpu_register_file_ccr (
  input  wire        clock,
  input  wire        rst,
  input  wire        writeEn,
  input  wire [3:0]  writeSel,
  input  wire [1:0]  writeSize,
  input  wire [31:0] writeData,
  input  wire [3:0]  readSelA,
  input  wire [1:0]  readSizeA,
  output reg  [31:0] readDataA,
  input  wire [3:0]  readSelB,
  input  wire [1:0]  readSizeB,
  output reg  [31:0] readDataB,
  input  wire        stackWriteEn,
  input  wire [31:0] stackWriteData,
  output wire [31:0] stackPointer,
  input  wire        pointerLoad,
  input  wire [23:0] pointerValue,
  output wire [23:0] nextInstructionPointer,
  output wire [23:0] fetchAddress,
  input  wire [23:0] dataAddress,
  input  wire [1:0]  dataSize,
  output wire [23:0] alignedAddress,
  input  wire        resetVectorLoad,
  input  wire        exceptionStart,
  input  wire [2:0]  flagOp,
  input  wire [7:0]  flagImm,
  input  wire [1:0]  opSize,
  input  wire [31:0] opResult,
  input  wire [31:0] opCarryVec,
  input  wire        opCarry,
  input  wire        opOverflow,
  input  wire        opKeepCarry,
  input  wire        bitAccValue,
  output wire [7:0]  conditionFlags,
  input  wire        interruptRequest,
  input  wire        nmiRequest,
  output wire        interruptAccept,
  output wire        userMaskBit,
  input  wire [3:0]  branchCond,
  output reg         branchTaken,
  input  wire [2:0]  bitIndex,
  input  wire [7:0]  bitOperand,
  output wire        selectedBit,
  input  wire [7:0]  bcdOperand,
  output wire [3:0]  bcdUpperDigit,
  output wire [3:0]  bcdLowerDigit
);
  reg  [31:0] gprReg [0:7];
  reg  [31:0] gprNext;
  reg  [23:0] pointerReg;
  reg  [7:0]  flagReg;
  reg  [7:0]  flagNext;
  wire        negFlag;
  wire        zeroFlag;
  wire        halfFlag;
  wire        flagNeg;
  wire        flagZero;
  wire        flagOvf;
  wire        flagCarry;
  integer     k;

  //////////////////////////////////////////////////////////////////////////////
  // Read ports show zero-extended views
  function [31:0] readView;
    input [31:0] full;
    input [3:0]  sel;
    input [1:0]  size;
    begin
      if (size == `SIZE_LONG) begin
        readView = full; // [RQ1]
      end else if (size == `SIZE_WORD) begin
        readView = sel[3] ? {16'h0000, full[31:16]} : {16'h0000, full[15:0]}; // [RQ2] [RQ3]
      end else begin
        readView = sel[3] ? {24'h000000, full[7:0]} : {24'h000000, full[15:8]}; // [RQ4]
      end
    end
  endfunction

  always @* begin
    readDataA = readView(gprReg[readSelA[2:0]], readSelA, readSizeA);
    readDataB = readView(gprReg[readSelB[2:0]], readSelB, readSizeB);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Merge a write of any width into the old register word
  function [31:0] writeMerge;
    input [31:0] old;
    input [3:0]  sel;
    input [1:0]  size;
    input [31:0] data;
    begin
      writeMerge = old;
      if (size == `SIZE_LONG) begin
        writeMerge = data; // [RQ1]
      end else if (size == `SIZE_WORD) begin
        if (sel[3]) begin
          writeMerge[31:16] = data[15:0]; // [RQ3]
        end else begin
          writeMerge[15:0] = data[15:0]; // [RQ2]
        end
      end else begin
        if (sel[3]) begin
          writeMerge[7:0] = data[7:0]; // [RQ4]
        end else begin
          writeMerge[15:8] = data[7:0]; // [RQ4]
        end
      end
    end
  endfunction

  always @* begin
    gprNext = writeMerge(gprReg[writeSel[2:0]], writeSel, writeSize, writeData);
  end

  // General registers are left uninitialized by reset
  always @(posedge clock) begin
    for (k = 0; k < `GPR_COUNT; k = k + 1) begin
      if (stackWriteEn && k == `STACK_INDEX) begin
        gprReg[k] <= stackWriteData; // [RQ5]
      end else if (writeEn && writeSel[2:0] == k) begin
        gprReg[k] <= gprNext;
      end
    end
  end

  assign stackPointer = gprReg[`STACK_INDEX]; // [RQ5]

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pointerReg <= `PTR_RESET;
    end else if (resetVectorLoad || pointerLoad) begin
      pointerReg <= pointerValue; // [RQ19]
    end
  end

  // Word and long accesses start at the even address below
  function [23:0] evenAddress;
    input [23:0] addr;
    begin
      evenAddress = {addr[23:1], 1'b0};
    end
  endfunction

  assign nextInstructionPointer = pointerReg;
  assign fetchAddress   = evenAddress(pointerReg); // [RQ6] [RQ21]
  assign alignedAddress = (dataSize == `SIZE_BYTE) ? dataAddress
                                                   : evenAddress(dataAddress); // [RQ21]

  //////////////////////////////////////////////////////////////////////////////
  flag_calc calc (
    .opSize       (opSize),
    .result       (opResult),
    .halfCarryVec (opCarryVec),
    .negFlag      (negFlag),
    .zeroFlag     (zeroFlag),
    .halfFlag     (halfFlag)
  );

  always @* begin
    flagNext = flagReg;
    case (flagOp)
      `FOP_LOAD: flagNext = flagImm; // [RQ17] [RQ9] [RQ11]
      `FOP_AND: flagNext = flagReg & flagImm; // [RQ17]
      `FOP_OR: flagNext = flagReg | flagImm; // [RQ17]
      `FOP_XOR: flagNext = flagReg ^ flagImm; // [RQ17]
      `FOP_ARITH: begin
        flagNext[`FLAG_HALF_BIT]  = halfFlag; // [RQ10]
        flagNext[`FLAG_NEG_BIT]   = negFlag; // [RQ12]
        flagNext[`FLAG_ZERO_BIT]  = zeroFlag; // [RQ13]
        flagNext[`FLAG_OVF_BIT]   = opOverflow; // [RQ14]
        if (!opKeepCarry) begin
          flagNext[`FLAG_CARRY_BIT] = opCarry; // [RQ15]
        end
      end
      `FOP_LOGIC: begin
        flagNext[`FLAG_NEG_BIT]  = negFlag; // [RQ12]
        flagNext[`FLAG_ZERO_BIT] = zeroFlag; // [RQ13]
        flagNext[`FLAG_OVF_BIT]  = 1'b0;
        if (!opKeepCarry) begin
          flagNext[`FLAG_CARRY_BIT] = opCarry; // [RQ15]
        end
      end
      `FOP_BITACC: flagNext[`FLAG_CARRY_BIT] = bitAccValue; // [RQ16]
      default: flagNext = flagReg;
    endcase
    if (exceptionStart) begin
      flagNext[`FLAG_MASK_BIT] = 1'b1; // [RQ8]
    end
  end

  // Reset sets the mask bit and clears every other flag bit
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flagReg <= `FLAG_RESET; // [RQ19]
    end else begin
      flagReg <= flagNext;
    end
  end

  // Flag views used by branch decoding
  assign flagNeg         = flagReg[`FLAG_NEG_BIT];
  assign flagZero        = flagReg[`FLAG_ZERO_BIT];
  assign flagOvf         = flagReg[`FLAG_OVF_BIT];
  assign flagCarry       = flagReg[`FLAG_CARRY_BIT];

  assign conditionFlags  = flagReg;
  assign userMaskBit     = flagReg[`FLAG_USERMASK_BIT]; // [RQ9]
  assign interruptAccept = nmiRequest
                        || (interruptRequest && !flagReg[`FLAG_MASK_BIT]); // [RQ7]

  //////////////////////////////////////////////////////////////////////////////
  // Branch conditions in the usual sixteen-way order
  function branchEval;
    input [3:0] cond;
    input       n;
    input       z;
    input       v;
    input       c;
    begin
      case (cond)
        4'h0: branchEval = 1'b1;
        4'h1: branchEval = 1'b0;
        4'h2: branchEval = ~(c | z); // [RQ18]
        4'h3: branchEval = c | z; // [RQ18]
        4'h4: branchEval = ~c; // [RQ18]
        4'h5: branchEval = c; // [RQ18]
        4'h6: branchEval = ~z; // [RQ18]
        4'h7: branchEval = z; // [RQ18]
        4'h8: branchEval = ~v; // [RQ18]
        4'h9: branchEval = v; // [RQ18]
        4'hA: branchEval = ~n; // [RQ18]
        4'hB: branchEval = n; // [RQ18]
        4'hC: branchEval = ~(n ^ v); // [RQ18]
        4'hD: branchEval = n ^ v; // [RQ18]
        4'hE: branchEval = ~(z | (n ^ v)); // [RQ18]
        default: branchEval = z | (n ^ v); // [RQ18]
      endcase
    end
  endfunction

  always @* begin
    branchTaken = branchEval(branchCond, flagNeg, flagZero, flagOvf, flagCarry); // [RQ18]
  end

  //////////////////////////////////////////////////////////////////////////////
  assign selectedBit   = bitOperand[bitIndex]; // [RQ22]
  assign bcdUpperDigit = bcdOperand[7:4]; // [RQ23]
  assign bcdLowerDigit = bcdOperand[3:0]; // [RQ23]
endmodule

/* common/cpu_register_file_ccr_regs.vh */
`ifndef CPU_REGISTER_FILE_CCR_REGS_VH
`define CPU_REGISTER_FILE_CCR_REGS_VH
`define GPR_COUNT        8
`define GPR_WIDTH        32
`define PTR_WIDTH        24
`define FLAG_WIDTH       8
`define STACK_INDEX      3'h7
`define FLAG_MASK_BIT    7
`define FLAG_USERMASK_BIT 6
`define FLAG_HALF_BIT    5
`define FLAG_USER_BIT    4
`define FLAG_NEG_BIT     3
`define FLAG_ZERO_BIT    2
`define FLAG_OVF_BIT     1
`define FLAG_CARRY_BIT   0
`define FLAG_RESET       8'h80
`define PTR_RESET        24'h000000
`define SIZE_BYTE        2'h0
`define SIZE_WORD        2'h1
`define SIZE_LONG        2'h2
`define FOP_NONE         3'h0
`define FOP_LOAD         3'h1
`define FOP_AND          3'h2
`define FOP_OR           3'h3
`define FOP_XOR          3'h4
`define FOP_ARITH        3'h5
`define FOP_LOGIC        3'h6
`define FOP_BITACC       3'h7
`endif

/* src/flag_calc.v */
`timescale 1ns/1ps
`include "cpu_register_file_ccr_regs.vh"
module flag_calc (
  input  wire [1:0]  opSize,
  input  wire [31:0] result,
  input  wire [31:0] halfCarryVec,
  output reg         negFlag,
  output reg         zeroFlag,
  output reg         halfFlag
);
  always @* begin
    negFlag  = 1'b0;
    zeroFlag = 1'b0;
    halfFlag = 1'b0;
    case (opSize)
      `SIZE_BYTE: begin
        negFlag  = result[7]; // [RQ12]
        zeroFlag = (result[7:0] == 8'h00); // [RQ13]
        halfFlag = halfCarryVec[3]; // [RQ10]
      end
      `SIZE_WORD: begin
        negFlag  = result[15]; // [RQ12]
        zeroFlag = (result[15:0] == 16'h0000); // [RQ13]
        halfFlag = halfCarryVec[11]; // [RQ10]
      end
      default: begin
        negFlag  = result[31]; // [RQ12]
        zeroFlag = (result == 32'h00000000); // [RQ13]
        halfFlag = halfCarryVec[27]; // [RQ10]
      end
    endcase
  end
endmodule

/* bench/core_exec_model.sv */
`timescale 1ns/1ps
module core_exec_model (
  input  wire [31:0] opA,
  input  wire [31:0] opB,
  input  wire [1:0]  opSize,
  output reg  [31:0] opResult,
  output reg  [31:0] opCarryVec,
  output reg         opCarry,
  output reg         opOverflow
);
  reg     top;
  integer m;
  // Execution adder, reports the carry out of every bit
  always @* begin
    m = opSize == 2'h0 ? 7 : opSize == 2'h1 ? 15 : 31;
    {top, opResult} = {1'b0, opA} + {1'b0, opB};
    opCarryVec = {top, opA[31:1] ^ opB[31:1] ^ opResult[31:1]};
    opCarry = opCarryVec[m];
    opOverflow = opCarryVec[m] ^ opCarryVec[m - 1];
  end
endmodule

/* bench/ccr_monitor.sv */
`timescale 1ns/1ps
module ccr_monitor (
  input wire        clock,
  input wire        rst,
  input wire        pointerLoad,
  input wire        resetVectorLoad,
  input wire [23:0] pointerValue,
  input wire [23:0] nextInstructionPointer,
  input wire [23:0] fetchAddress,
  input wire        exceptionStart,
  input wire [2:0]  flagOp,
  input wire [7:0]  flagImm,
  input wire [7:0]  conditionFlags,
  input wire        interruptRequest,
  input wire        nmiRequest,
  input wire        interruptAccept,
  input wire        userMaskBit
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_irq; interruptAccept == (nmiRequest | interruptRequest & ~conditionFlags[7]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt accept wrong");
  property p_exc; exceptionStart |=> conditionFlags[7]; endproperty
  a_exc: assert property (p_exc) else $error("mask not set");
  property p_load; flagOp == 3'h1 && !exceptionStart |=> conditionFlags == $past(flagImm); endproperty
  a_load: assert property (p_load) else $error("flag load wrong");
  property p_and; flagOp == 3'h2 |=> conditionFlags[6:0] == $past(conditionFlags[6:0] & flagImm[6:0]); endproperty
  a_and: assert property (p_and) else $error("flag and wrong");
  property p_hold; flagOp == 3'h0 && !exceptionStart |=> $stable(conditionFlags); endproperty
  a_hold: assert property (p_hold) else $error("flags changed");
  property p_ptr; pointerLoad | resetVectorLoad |=> nextInstructionPointer == $past(pointerValue); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load wrong");
  property p_fetch; fetchAddress == {nextInstructionPointer[23:1], 1'b0}; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address odd");
  property p_user; userMaskBit == conditionFlags[6]; endproperty
  a_user: assert property (p_user) else $error("user mask bit wrong");
  c_exc: cover property (exceptionStart ##1 conditionFlags[7]);
  c_nmi: cover property (nmiRequest && conditionFlags[7]);
  c_ptr: cover property (pointerLoad ##1 nextInstructionPointer[0]);
endmodule
bind cpu_register_file_ccr ccr_monitor ccr_monitor_i (.clock, .rst, .pointerLoad, .resetVectorLoad,
  .pointerValue, .nextInstructionPointer, .fetchAddress, .exceptionStart, .flagOp, .flagImm,
  .conditionFlags, .interruptRequest, .nmiRequest, .interruptAccept, .userMaskBit);

/* bench/cpu_register_file_ccr_tb.sv */
`timescale 1ns/1ps
module cpu_register_file_ccr_tb;
  reg         clock, rst, writeEn, stackWriteEn, pointerLoad, resetVectorLoad, exceptionStart;
  reg         opKeepCarry, bitAccValue, interruptRequest, nmiRequest;
  reg  [3:0]  writeSel, readSelA, readSelB, branchCond;
  reg  [1:0]  writeSize, readSizeA, readSizeB, dataSize, opSize;
  reg  [31:0] writeData, stackWriteData, opA, opB, d;
  reg  [23:0] pointerValue, dataAddress, p;
  reg  [2:0]  flagOp, bitIndex;
  reg  [7:0]  flagImm, bitOperand, bcdOperand, f, v;
  wire [31:0] readDataA, readDataB, stackPointer, opResult, opCarryVec;
  wire [23:0] nextInstructionPointer, fetchAddress, alignedAddress;
  wire [7:0]  conditionFlags;
  wire [3:0]  bcdUpperDigit, bcdLowerDigit;
  wire        opCarry, opOverflow, interruptAccept, userMaskBit, branchTaken, selectedBit;
  integer     err_total = 0, samples_checked = 0, seed = 31, cycles = 0, i;
  cpu_register_file_ccr cpu_register_file_ccr_i (.*);
  core_exec_model core_exec_model_i (.*);
  function [7:0] arithFlags(input [7:0] o, input [1:0] s, input [31:0] r, cv, input ov, c);
    integer m;
    begin
      m = s == 2'h0 ? 7 : s == 2'h1 ? 15 : 31;
      arithFlags = {o[7:6], cv[m - 4], o[4], r[m], (r << (31 - m)) == 32'h0, ov, c};
    end
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [3:0] s, input [1:0] z, input [31:0] x);
    begin
      @(posedge clock);
      writeEn <= 1'b1;
      writeSel <= s;
      writeSize <= z;
      writeData <= x;
    end
  endtask
  task rd(input [3:0] sa, input [1:0] za, input [3:0] sb, input [1:0] zb);
    begin
      @(posedge clock);
      writeEn <= 1'b0;
      stackWriteEn <= 1'b0;
      readSelA <= sa;
      readSizeA <= za;
      readSelB <= sb;
      readSizeB <= zb;
      #1;
    end
  endtask
  task flg(input [2:0] o, input [7:0] m, input x);
    begin
      @(posedge clock);
      flagOp <= o;
      flagImm <= m;
      exceptionStart <= x;
      @(posedge clock);
      flagOp <= 3'h0;
      exceptionStart <= 1'b0;
      #1;
    end
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  initial begin
    {writeEn, stackWriteEn, pointerLoad, resetVectorLoad, exceptionStart, opKeepCarry, bitAccValue,
     interruptRequest, nmiRequest, writeSel, readSelA, readSelB, branchCond, writeSize, readSizeA,
     readSizeB, dataSize, opSize, writeData, stackWriteData, opA, opB, pointerValue, dataAddress,
     flagOp, bitIndex, flagImm, bitOperand, bcdOperand} = 0;
    rst = 1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd(4'h0, 2'h2, 4'h0, 2'h2);
    chk(conditionFlags, 8'h80);
    d = $random(seed);
    @(posedge clock);
    stackWriteEn <= 1'b1;
    stackWriteData <= d;
    rd(4'h7, 2'h2, 4'hF, 2'h1);
    chk(stackPointer, d);
    chk(readDataB, {16'h0, d[31:16]});
    $display("stack test done");
    for (i = 0; i < 8; i = i + 1) begin
      d = $random(seed);
      wr({1'b0, i[2:0]}, 2'h2, d);
      rd({1'b1, i[2:0]}, 2'h1, {1'b0, i[2:0]}, 2'h0);
      chk(readDataA, {16'h0, d[31:16]});
      chk(readDataB, {24'h0, d[15:8]});
      wr({1'b1, i[2:0]}, 2'h0, 32'h0000005A);
      rd({1'b0, i[2:0]}, 2'h2, {1'b0, i[2:0]}, 2'h1);
      chk(readDataA, {d[31:8], 8'h5A});
      chk(readDataB, {16'h0, d[15:8], 8'h5A});
    end
    $display("register test done");
    for (i = 1; i < 5; i = i + 1) begin
      d = $random(seed);
      flg(i[2:0], d[7:0], 1'b0);
      f = i == 1 ? d[7:0] : i == 2 ? f & d[7:0] : i == 3 ? f | d[7:0] : f ^ d[7:0];
      chk(conditionFlags, f);
      chk(userMaskBit, f[6]);
    end
    for (i = 0; i < 12; i = i + 1) begin
      d = $random(seed);
      opA <= d;
      opB <= i % 4 == 0 ? -d : $random(seed);
      opSize <= i % 3;
      opKeepCarry <= i[1];
      bitAccValue <= d[9];
      flg(i % 4 == 3 ? 3'h7 : 3'h5, 8'h00, 1'b0);
      f = i % 4 == 3 ? {f[7:1], d[9]} :
          arithFlags(f, opSize, opResult, opCarryVec, opOverflow, i[1] ? f[0] : opCarry);
      chk(conditionFlags, f);
    end
    $display("flag test done");
    p = 24'h000000;
    for (i = 0; i < 32; i = i + 1) begin
      d = $random(seed);
      @(posedge clock);
      pointerLoad <= i[0];
      resetVectorLoad <= ~i[0];
      pointerValue <= d[23:0];
      dataAddress <= d[23:0];
      dataSize <= i % 3;
      bitIndex <= d[26:24];
      bitOperand <= d[7:0];
      bcdOperand <= d[31:24];
      branchCond <= i[3:0];
      interruptRequest <= d[28];
      nmiRequest <= d[29];
      #1;
      v = {f[2] | f[3] ^ f[1], f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
      chk(branchTaken, v[i[3:1]] == i[0]);
      chk(alignedAddress, {d[23:1], d[0] & i % 3 == 0});
      chk(selectedBit, d[d[26:24]]);
      chk({bcdUpperDigit, bcdLowerDigit}, d[31:24]);
      chk(interruptAccept, d[29] | d[28] & ~f[7]);
      chk(fetchAddress, {p[23:1], 1'b0});
      p = d[23:0];
      if (i == 16)
        flg(3'h1, 8'h00, 1'b1);
      f = i == 16 ? 8'h80 : f;
      chk(conditionFlags, f);
    end
    $display("datapath test done");
    test_done;
  end
endmodule
